// ===== src/clsv_cfg.svh
// Constants for the closed-loop steering valve control block.
// Assumes a 250 MHz system clock and parameter indices as used by the command port.
`ifndef CLSV_CFG_SVH
`define CLSV_CFG_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLSV_CLK_PERIOD_PS 4000
`define CLSV_MS_PS 1000000000
`define CLSV_MS_CYCLES (`CLSV_MS_PS / `CLSV_CLK_PERIOD_PS)

// ****************************************************************
// Parameter indices
// ****************************************************************
`define CLSV_IDX_GAIN 16'h01FC
`define CLSV_IDX_OFF_DELAY 16'h0203
`define CLSV_IDX_HOLD 16'h0205
`define CLSV_IDX_DEADBAND 16'h0206
`define CLSV_IDX_OFFSET 16'h02EC
`define CLSV_IDX_WHEEL_THR 16'hFA16
`define CLSV_IDX_WINDOW 16'hFA17
`define CLSV_IDX_LIMIT 16'h0300
`define CLSV_IDX_SCALE 16'h0301
`define CLSV_IDX_SELECT 16'h0302
`define CLSV_IDX_SENS0 16'h0303
`define CLSV_IDX_SPAN 16'h0309
`define CLSV_IDX_STATUS 16'h0310

// ****************************************************************
// Reset values, upper limits, select codes and divisors
// ****************************************************************
`define CLSV_RST_GAIN 16'h0032
`define CLSV_RST_OFF_DELAY 16'h7530
`define CLSV_RST_HOLD 16'h0BB8
`define CLSV_RST_DEADBAND 16'h0032
`define CLSV_RST_OFFSET 16'h0000
`define CLSV_RST_WHEEL_THR 16'h0005
`define CLSV_RST_WINDOW 32'h7FFFFFFF
`define CLSV_RST_LIMIT 16'h03E8
`define CLSV_RST_SCALE 16'h03E8
`define CLSV_RST_SELECT 8'h01
`define CLSV_RST_SENS 16'h03E8
`define CLSV_RST_SPAN 16'h01F4
`define CLSV_MAX_GAIN 16'h00C8
`define CLSV_MAX_MS 16'h7530
`define CLSV_MAX_DEADBAND 16'h0064
`define CLSV_MAX_THOUSAND 16'h03E8
`define CLSV_MAX_SCALE 16'h07D0
`define CLSV_MAX_WHEEL_THR 16'h0FFF
`define CLSV_MAX_SENS 16'h04B0
`define CLSV_SEL_FIXED 8'h01
`define CLSV_SEL_SPEED 8'h03
`define CLSV_SCALE_DIV 33'sh0000003E8
`define CLSV_FLOW_DIV 56'sh0000000000000A
`define CLSV_SENS_DIV 56'sh000000000003E8

`endif

// ===== src/clsv_pkg.sv
// Types shared by the closed-loop steering valve control block.
// Assumes nothing of its surroundings.
package clsv_pkg;
  typedef enum logic [1:0] {
    CLSV_SPOOL_ACTIVE = 2'b01,
    CLSV_SPOOL_NEUTRAL = 2'b10
  } clsv_spool_t;

  typedef enum logic [1:0] {
    CLSV_BRIDGE_ON = 2'b01,
    CLSV_BRIDGE_OFF = 2'b10
  } clsv_bridge_t;
endpackage : clsv_pkg

// ===== src/clsv_steer_ctrl.sv
// Closed-loop steering valve control: set-point scaling, proportional flow, flow limit,
// spool overlap offset, neutral dead-band, speed sensitivity, valve bridge and engage gating.
// Assumes set-points, position, speed and wheel delta come from logic on mclk.
//
// Function
// R1 - Proportional gain 0..200, default 50
// R2 - Clamp port flow to limit, default 1000
// R3 - Scale set-point by setting times 0.001
// R4 - Spool offset 0..1000, default 0
// R5 - Neutralise spool after dead-band held long enough
// R6 - Reactivate spool when flow exceeds dead-band
// R7 - Neutral hold time 1..30000 ms, default 3000
// R8 - Flow dead-band 0..100, default 50
// R9 - Select 1 fixed, 3 speed sensitivity
// R10 - Fixed mode scales by first sensitivity point
// R11 - Speed mode interpolates linearly between points
// R12 - Speed magnitude used, negative speeds symmetric
// R13 - Points at 0, 6.25..100 percent span
// R14 - Speed span 1..1000, default 500
// R15 - Software keeps sensitivity table non-rising
// R16 - Unmapped speed uses standstill point constantly
// R17 - Disable bridge after zero flow delay
// R18 - Enable bridge at once on non-zero flow
// R19 - Off delay 1..30000, 30000 disables shutdown
// R20 - Software sets short delay without motion sensor
// R21 - Engage only when wheel delta exceeds threshold
// R22 - Engage window after motion; all-ones disables; code disables at 7FFFFFFF and refuses larger writes
`timescale 1ns/1ps
`include "clsv_cfg.svh"

module clsv_steer_ctrl #(
  parameter int unsigned TICK_CYCLES = `CLSV_MS_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Parameter command port
  input wire logic paramWrite,
  input wire logic paramRead,
  input wire logic [15:0] paramIndex,
  input wire logic [31:0] paramData,
  output logic [31:0] paramReadData,
  output logic paramReadValid,
  output logic paramError,
  // Guidance set-point and measured position, 0.1 percent units
  input wire logic setpointValid,
  input wire logic signed [15:0] setpointValue,
  input wire logic signed [15:0] positionValue,
  // Vehicle speed, 0.1 km/h
  input wire logic speedMapped,
  input wire logic signed [15:0] vehicleSpeedValue,
  // Steering wheel motion sensor
  input wire logic signed [15:0] wheelPositionDelta,
  // Valve outputs
  output logic signed [15:0] flowCommand,
  output logic signed [15:0] spoolCommand,
  output logic spoolNeutral,
  output logic bridgeEnable,
  output logic engageAllowed
);

  // ****************************************************************
  // Parameter registers
  // ****************************************************************
  logic [15:0] proportionalGain_reg;
  logic [15:0] valveOffDelay_reg;
  logic [15:0] neutralHold_reg;
  logic [15:0] deadband_reg;
  logic [15:0] spoolOffset_reg;
  logic [15:0] wheelThreshold_reg;
  logic [31:0] engageWindow_reg;
  logic [15:0] portFlowLimit_reg;
  logic [15:0] setpointScale_reg;
  logic [7:0] sensSelect_reg;
  logic [15:0] sensPoint_reg [0:5];
  logic [15:0] speedSpan_reg;
  logic writeOk;
  logic [2:0] sensSlot;
  logic sensHit;

  assign sensSlot = 3'(paramIndex - `CLSV_IDX_SENS0);
  // The full index is compared, since the three-bit slot alone would alias other indices.
  assign sensHit = paramIndex >= `CLSV_IDX_SENS0 && paramIndex <= `CLSV_IDX_SENS0 + 16'h0005;

  // Out-of-range writes are refused whole so a bad command cannot leave a half-valid setting.
  always_comb begin
    case (paramIndex)
      `CLSV_IDX_GAIN: writeOk = paramData <= 32'(`CLSV_MAX_GAIN); // R1
      `CLSV_IDX_LIMIT: writeOk = paramData <= 32'(`CLSV_MAX_THOUSAND); // R2
      `CLSV_IDX_SCALE: writeOk = paramData <= 32'(`CLSV_MAX_SCALE); // R3
      `CLSV_IDX_OFFSET: writeOk = paramData <= 32'(`CLSV_MAX_THOUSAND); // R4
      `CLSV_IDX_HOLD, `CLSV_IDX_OFF_DELAY: begin
        writeOk = paramData != 32'h0 && paramData <= 32'(`CLSV_MAX_MS); // R7 R19
      end
      `CLSV_IDX_DEADBAND: writeOk = paramData <= 32'(`CLSV_MAX_DEADBAND); // R8
      `CLSV_IDX_SELECT: begin
        writeOk = paramData == 32'(`CLSV_SEL_FIXED) || paramData == 32'(`CLSV_SEL_SPEED); // R9
      end
      `CLSV_IDX_SPAN: begin
        writeOk = paramData != 32'h0 && paramData <= 32'(`CLSV_MAX_THOUSAND); // R14
      end
      `CLSV_IDX_WHEEL_THR: writeOk = paramData <= 32'(`CLSV_MAX_WHEEL_THR); // R21
      `CLSV_IDX_WINDOW: writeOk = paramData <= `CLSV_RST_WINDOW; // R22
      default: begin
        writeOk = sensHit && paramData <= 32'(`CLSV_MAX_SENS);
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      proportionalGain_reg <= `CLSV_RST_GAIN;
      valveOffDelay_reg <= `CLSV_RST_OFF_DELAY;
      neutralHold_reg <= `CLSV_RST_HOLD;
      deadband_reg <= `CLSV_RST_DEADBAND;
      spoolOffset_reg <= `CLSV_RST_OFFSET;
      wheelThreshold_reg <= `CLSV_RST_WHEEL_THR;
      engageWindow_reg <= `CLSV_RST_WINDOW;
      portFlowLimit_reg <= `CLSV_RST_LIMIT;
      setpointScale_reg <= `CLSV_RST_SCALE;
      sensSelect_reg <= `CLSV_RST_SELECT;
      speedSpan_reg <= `CLSV_RST_SPAN;
      for (int i = 0; i < 6; i++) begin
        sensPoint_reg[i] <= `CLSV_RST_SENS;
      end
    end else if (paramWrite && writeOk) begin
      case (paramIndex)
        `CLSV_IDX_GAIN: proportionalGain_reg <= paramData[15:0];
        `CLSV_IDX_OFF_DELAY: valveOffDelay_reg <= paramData[15:0];
        `CLSV_IDX_HOLD: neutralHold_reg <= paramData[15:0];
        `CLSV_IDX_DEADBAND: deadband_reg <= paramData[15:0];
        `CLSV_IDX_OFFSET: spoolOffset_reg <= paramData[15:0];
        `CLSV_IDX_WHEEL_THR: wheelThreshold_reg <= paramData[15:0];
        `CLSV_IDX_WINDOW: engageWindow_reg <= paramData;
        `CLSV_IDX_LIMIT: portFlowLimit_reg <= paramData[15:0];
        `CLSV_IDX_SCALE: setpointScale_reg <= paramData[15:0];
        `CLSV_IDX_SELECT: sensSelect_reg <= paramData[7:0];
        `CLSV_IDX_SPAN: speedSpan_reg <= paramData[15:0];
        default: sensPoint_reg[sensSlot] <= paramData[15:0];
      endcase
    end
  end

  // ****************************************************************
  // Parameter read-back and command answers
  // ****************************************************************
  logic readHit;
  logic [31:0] readValue;

  always_comb begin
    readHit = 1'b1;
    case (paramIndex)
      `CLSV_IDX_GAIN: readValue = {16'h0, proportionalGain_reg};
      `CLSV_IDX_OFF_DELAY: readValue = {16'h0, valveOffDelay_reg};
      `CLSV_IDX_HOLD: readValue = {16'h0, neutralHold_reg};
      `CLSV_IDX_DEADBAND: readValue = {16'h0, deadband_reg};
      `CLSV_IDX_OFFSET: readValue = {16'h0, spoolOffset_reg};
      `CLSV_IDX_WHEEL_THR: readValue = {16'h0, wheelThreshold_reg};
      `CLSV_IDX_WINDOW: readValue = engageWindow_reg;
      `CLSV_IDX_LIMIT: readValue = {16'h0, portFlowLimit_reg};
      `CLSV_IDX_SCALE: readValue = {16'h0, setpointScale_reg};
      `CLSV_IDX_SELECT: readValue = {24'h0, sensSelect_reg};
      `CLSV_IDX_SPAN: readValue = {16'h0, speedSpan_reg};
      `CLSV_IDX_STATUS: begin
        readValue = {13'h0, engageAllowed, bridgeEnable, spoolNeutral, flowCommand};
      end
      default: begin
        readHit = sensHit;
        readValue = readHit ? {16'h0, sensPoint_reg[sensSlot]} : 32'h0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      paramReadData <= 32'h0;
      paramReadValid <= 1'b0;
      paramError <= 1'b0;
    end else begin
      paramReadValid <= paramRead && readHit;
      paramReadData <= (paramRead && readHit) ? readValue : 32'h0;
      paramError <= (paramRead && !readHit) || (paramWrite && !writeOk);
    end
  end

  // ****************************************************************
  // Millisecond tick
  // ****************************************************************
  logic [31:0] tickCount_reg;
  logic msTick;

  assign msTick = tickCount_reg == TICK_CYCLES - 1;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tickCount_reg <= 32'h0;
    end else begin
      tickCount_reg <= msTick ? 32'h0 : tickCount_reg + 32'h1;
    end
  end

  // ****************************************************************
  // Speed-dependent sensitivity
  // ****************************************************************
  logic [15:0] speedAbs;
  logic [15:0] breakPoint [0:5];
  logic [15:0] sensValue;

  // An unmapped speed reads as standstill, so the first point applies constantly unless speed mode has a span below 16.
  assign speedAbs = !speedMapped ? 16'h0 : // R16
                    vehicleSpeedValue[15] ? 16'(-vehicleSpeedValue) : vehicleSpeedValue; // R12

  assign breakPoint[0] = 16'h0;
  for (genvar k = 1; k < 6; k++) begin : gen_break
    assign breakPoint[k] = speedSpan_reg >> (5 - k); // R13 R14
  end

  always_comb begin
    logic [2:0] seg;
    logic signed [33:0] slope;
    logic [15:0] den;
    seg = 3'h0;
    slope = 34'sh0;
    den = 16'h0;
    sensValue = sensPoint_reg[0];
    if (sensSelect_reg == `CLSV_SEL_SPEED) begin // R9
      for (int k = 1; k < 5; k++) begin
        if (speedAbs >= breakPoint[k]) begin
          seg = 3'(k);
        end
      end
      den = breakPoint[seg + 3'h1] - breakPoint[seg];
      slope = ($signed({18'h0, sensPoint_reg[seg + 3'h1]}) - $signed({18'h0, sensPoint_reg[seg]}))
              * $signed({18'h0, 16'(speedAbs - breakPoint[seg])});
      if (speedAbs >= breakPoint[5]) begin
        sensValue = sensPoint_reg[5];
      end else if (den != 16'h0) begin
        sensValue = 16'($signed({18'h0, sensPoint_reg[seg]}) + slope / $signed({18'h0, den})); // R11
      end
    end
  end

  // ****************************************************************
  // Flow command
  // ****************************************************************
  logic signed [32:0] scaledSetpoint;
  logic signed [33:0] controlError;
  logic signed [55:0] flowWide;
  logic [55:0] flowAbs;
  logic signed [15:0] flowNext;

  assign scaledSetpoint = ($signed(setpointValue) * $signed({1'b0, setpointScale_reg}))
                          / `CLSV_SCALE_DIV; // R3
  assign controlError = scaledSetpoint - positionValue;
  // Gain is 0.01 percent flow per 0.1 percent error; sensitivity scales in thousandths.
  assign flowWide = controlError * $signed({1'b0, proportionalGain_reg})
                    * $signed({1'b0, sensValue}) / (`CLSV_FLOW_DIV * `CLSV_SENS_DIV); // R1 R10
  assign flowAbs = flowWide[55] ? 56'(-flowWide) : 56'(flowWide);

  always_comb begin
    flowNext = flowWide[15:0];
    if (flowAbs > {40'h0, portFlowLimit_reg}) begin // R2
      flowNext = flowWide[55] ? 16'(-$signed({1'b0, portFlowLimit_reg})) : portFlowLimit_reg;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      flowCommand <= 16'sh0;
    end else if (setpointValid) begin
      flowCommand <= flowNext;
    end
  end

  // ****************************************************************
  // Spool neutralisation
  // ****************************************************************
  clsv_pkg::clsv_spool_t spoolState_reg;
  logic [15:0] holdCount_reg;
  logic [15:0] flowMag;
  logic withinBand;

  assign flowMag = flowCommand[15] ? 16'(-flowCommand) : flowCommand;
  assign withinBand = flowMag <= deadband_reg; // R8

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      spoolState_reg <= clsv_pkg::CLSV_SPOOL_ACTIVE;
      holdCount_reg <= 16'h0;
    end else begin
      case (spoolState_reg)
        clsv_pkg::CLSV_SPOOL_ACTIVE: begin
          if (!withinBand) begin
            holdCount_reg <= 16'h0;
          end else if (holdCount_reg >= neutralHold_reg) begin
            spoolState_reg <= clsv_pkg::CLSV_SPOOL_NEUTRAL; // R5 R7
          end else if (msTick) begin
            holdCount_reg <= holdCount_reg + 16'h1;
          end
        end
        clsv_pkg::CLSV_SPOOL_NEUTRAL: begin
          if (!withinBand) begin
            spoolState_reg <= clsv_pkg::CLSV_SPOOL_ACTIVE; // R6
            holdCount_reg <= 16'h0;
          end
        end
        default: begin
          spoolState_reg <= clsv_pkg::CLSV_SPOOL_ACTIVE;
          holdCount_reg <= 16'h0;
        end
      endcase
    end
  end

  assign spoolNeutral = spoolState_reg == clsv_pkg::CLSV_SPOOL_NEUTRAL;

  // The offset pushes the spool past its overlap so any non-zero flow command yields flow unless the spool is neutral.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      spoolCommand <= 16'sh0;
    end else if (spoolNeutral || flowCommand == 16'sh0) begin
      spoolCommand <= 16'sh0;
    end else begin
      spoolCommand <= flowCommand[15] ? 16'(flowCommand - $signed(spoolOffset_reg))
                                      : 16'(flowCommand + $signed(spoolOffset_reg)); // R4
    end
  end

  // ****************************************************************
  // Magnetic valve bridge
  // ****************************************************************
  clsv_pkg::clsv_bridge_t bridgeState_reg;
  logic [15:0] offCount_reg;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bridgeState_reg <= clsv_pkg::CLSV_BRIDGE_ON;
      offCount_reg <= 16'h0;
    end else if (flowCommand != 16'sh0 || valveOffDelay_reg == `CLSV_MAX_MS) begin
      bridgeState_reg <= clsv_pkg::CLSV_BRIDGE_ON; // R18 R19
      offCount_reg <= 16'h0;
    end else begin
      case (bridgeState_reg)
        clsv_pkg::CLSV_BRIDGE_ON: begin
          if (offCount_reg >= valveOffDelay_reg) begin
            bridgeState_reg <= clsv_pkg::CLSV_BRIDGE_OFF; // R17
          end else if (msTick) begin
            offCount_reg <= offCount_reg + 16'h1;
          end
        end
        clsv_pkg::CLSV_BRIDGE_OFF: offCount_reg <= offCount_reg;
        default: bridgeState_reg <= clsv_pkg::CLSV_BRIDGE_ON;
      endcase
    end
  end

  assign bridgeEnable = bridgeState_reg == clsv_pkg::CLSV_BRIDGE_ON;

  // ****************************************************************
  // Auto-steering engage gating
  // ****************************************************************
  logic [15:0] deltaAbs;
  logic wheelMoving;
  logic [31:0] windowCount_reg;

  assign deltaAbs = wheelPositionDelta[15] ? 16'(-wheelPositionDelta) : wheelPositionDelta;
  assign wheelMoving = deltaAbs > wheelThreshold_reg; // R21

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      windowCount_reg <= 32'h0;
    end else if (engageWindow_reg == `CLSV_RST_WINDOW) begin
      windowCount_reg <= 32'h0; // R22
    end else if (wheelMoving) begin
      windowCount_reg <= engageWindow_reg;
    end else if (msTick && windowCount_reg != 32'h0) begin
      windowCount_reg <= windowCount_reg - 32'h1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      engageAllowed <= 1'b0;
    end else begin
      engageAllowed <= wheelMoving || windowCount_reg != 32'h0; // R21 R22
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  flow_limit_a: assert property (setpointValid |=> flowMag <= $past(portFlowLimit_reg)) // R2
    else $error("flow command above port flow limit");
  spool_neutral_a: assert property ($rose(spoolNeutral) |-> // R5
      $past(withinBand) && $past(holdCount_reg) >= $past(neutralHold_reg))
    else $error("spool neutral before hold time");
  spool_reactivate_a: assert property (spoolNeutral && !withinBand |=> !spoolNeutral) // R6
    else $error("spool not reactivated");
  bridge_on_a: assert property (flowCommand != 16'sh0 |=> bridgeEnable) // R18
    else $error("bridge not enabled on flow");
  bridge_held_a: assert property (valveOffDelay_reg == `CLSV_MAX_MS |=> bridgeEnable) // R19
    else $error("bridge off while shutdown disabled");
  bridge_off_a: assert property ($fell(bridgeEnable) |-> // R17
      $past(flowCommand) == 16'sh0 && $past(offCount_reg) >= $past(valveOffDelay_reg))
    else $error("bridge off too early");
  engage_motion_a: assert property (wheelMoving |=> engageAllowed) // R21
    else $error("engage blocked during wheel motion");
  engage_window_a: assert property (engageWindow_reg == `CLSV_RST_WINDOW && !wheelMoving // R22
      ##1 engageWindow_reg == `CLSV_RST_WINDOW && !wheelMoving |=> !engageAllowed)
    else $error("engage held with window disabled");
  sens_fixed_a: assert property (sensSelect_reg == `CLSV_SEL_FIXED |-> // R10
      sensValue == sensPoint_reg[0])
    else $error("fixed sensitivity not first point");
  sens_unmapped_a: assert property (!speedMapped |-> sensValue == sensPoint_reg[0]) // R16
    else $error("unmapped speed not standstill point");
  spool_offset_a: assert property (!spoolNeutral && flowCommand > 16'sh0 ##1 // R4
      $stable(flowCommand) && !spoolNeutral |->
      spoolCommand == flowCommand + $signed($past(spoolOffset_reg)))
    else $error("spool offset not applied");

endmodule : clsv_steer_ctrl

// ===== verif/clsv_guidance_model.sv
// Guidance controller model: hands set-points and measured position to the valve control.
// Assumes the bench calls send, and that the control takes a set-point on a valid edge.
`timescale 1ns/1ps
module clsv_guidance_model (
  // Clock
  input wire logic mclk,
  // Set-point side
  output logic setpointValid,
  output logic signed [15:0] setpointValue,
  output logic signed [15:0] positionValue
);
  initial begin
    setpointValid = 1'b0;
    setpointValue = 16'sh0000;
    positionValue = 16'sh0000;
  end

  // The set-point is spoiled after its valid edge, so a late sample cannot pass by luck.
  task automatic send(input logic signed [15:0] sp, input logic signed [15:0] pos);
    @(posedge mclk);
    setpointValid <= 1'b1;
    setpointValue <= sp;
    positionValue <= pos;
    @(posedge mclk);
    setpointValid <= 1'b0;
    setpointValue <= ~sp;
  endtask : send
endmodule : clsv_guidance_model

// ===== verif/clsv_steer_ctrl_tb_top.sv
// Bench for the closed-loop steering valve control block.
// Assumes the design include path and a millisecond shortened to 4 clocks.
`timescale 1ns/1ps
`include "clsv_cfg.svh"
module clsv_steer_ctrl_tb_top;
  // ********************
  // Signals
  // ********************
  typedef struct {logic [15:0] gain; logic [15:0] scale; logic signed [15:0] sp;
    logic signed [15:0] pos; logic [15:0] flow;} clsv_row_t;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic paramWrite = 1'b0;
  logic paramRead = 1'b0;
  logic [15:0] paramIndex = 16'h0000;
  logic [31:0] paramData = 32'h0;
  logic [31:0] paramReadData, rdata;
  logic paramReadValid, paramError, setpointValid, spoolNeutral, bridgeEnable, engageAllowed;
  logic signed [15:0] setpointValue, positionValue, flowCommand, spoolCommand;
  logic speedMapped = 1'b0;
  logic signed [15:0] vehicleSpeedValue = 16'sh0000;
  logic signed [15:0] wheelPositionDelta = 16'sh0000;
  logic perr, pvld;
  int fail_count = 0;
  int compares = 0;
  clsv_row_t rows [6];
  logic [15:0] rstIdx [12] = '{`CLSV_IDX_GAIN, `CLSV_IDX_OFF_DELAY, `CLSV_IDX_HOLD,
    `CLSV_IDX_DEADBAND, `CLSV_IDX_OFFSET, `CLSV_IDX_WHEEL_THR, `CLSV_IDX_WINDOW,
    `CLSV_IDX_LIMIT, `CLSV_IDX_SCALE, `CLSV_IDX_SELECT, `CLSV_IDX_SENS0, `CLSV_IDX_SPAN};
  logic [31:0] rstVal [12] = '{32'h32, 32'h7530, 32'hBB8, 32'h32, 32'h0, 32'h5,
    32'h7FFFFFFF, 32'h3E8, 32'h3E8, 32'h1, 32'h3E8, 32'h1F4};
  logic [15:0] sens [6] = '{16'h03E8, 16'h0320, 16'h0258, 16'h0190, 16'h00C8, 16'h0064};
  logic signed [15:0] spd [4] = '{16'sh000F, 16'shFFF1, 16'sh0028, 16'sh00C8};
  logic [15:0] spdFlow [4] = '{16'h0046, 16'h0046, 16'h0028, 16'h000A};

  always #2 mclk = ~mclk;

  clsv_steer_ctrl #(.TICK_CYCLES(4)) DUT (.mclk(mclk), .reset(reset),
    .paramWrite(paramWrite), .paramRead(paramRead), .paramIndex(paramIndex),
    .paramData(paramData), .paramReadData(paramReadData), .paramReadValid(paramReadValid),
    .paramError(paramError), .setpointValid(setpointValid), .setpointValue(setpointValue),
    .positionValue(positionValue), .speedMapped(speedMapped),
    .vehicleSpeedValue(vehicleSpeedValue), .wheelPositionDelta(wheelPositionDelta),
    .flowCommand(flowCommand), .spoolCommand(spoolCommand), .spoolNeutral(spoolNeutral),
    .bridgeEnable(bridgeEnable), .engageAllowed(engageAllowed));

  clsv_guidance_model gc (.mclk(mclk), .setpointValid(setpointValid),
    .setpointValue(setpointValue), .positionValue(positionValue));

  // ********************
  // Tasks
  // ********************
  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkv

  task automatic chkb(input logic got, input logic exp);
    chkv({31'h0, got}, {31'h0, exp});
  endtask : chkb

  task automatic edges(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : edges

  task automatic param(input logic rd, input logic [15:0] idx, input logic [31:0] d);
    @(posedge mclk);
    paramRead <= rd;
    paramWrite <= ~rd;
    paramIndex <= idx;
    paramData <= d;
    @(posedge mclk);
    paramRead <= 1'b0;
    paramWrite <= 1'b0;
    #1;
    rdata = paramReadData;
    perr = paramError;
    pvld = paramReadValid;
  endtask : param

  // Flow is visible after the taking edge, the spool command one edge later.
  task automatic flowChk(input logic [15:0] sp, input logic [15:0] pos,
      input logic [15:0] f, input logic [15:0] s);
    gc.send(sp, pos);
    edges(1);
    chkv({16'h0, flowCommand}, {16'h0, f});
    chkv({16'h0, spoolCommand}, {16'h0, s});
  endtask : flowChk

  task automatic waitFor(input int sel, input logic v, input int lim);
    int n;
    n = 0;
    while (((sel == 0) ? spoolNeutral : (sel == 1) ? bridgeEnable : engageAllowed) !== v) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > lim) begin
        fail_count++;
        $display("mismatch at %0t: got %h expected %h", $time, ~v, v);
        tally_and_finish();
      end
    end
  endtask : waitFor

  // ********************
  // Sequence
  // ********************
  initial begin
    rows = '{'{16'h32, 16'h3E8, 16'sh64, 16'sh3C, 16'hC8},
      '{16'hC8, 16'h3E8, 16'sh1E, 16'sh0, 16'h258}, '{16'h32, 16'h7D0, 16'sh32, 16'sh0, 16'h1F4},
      '{16'h32, 16'h1F4, -16'sh50, 16'sh0, 16'hFF38}, '{16'h32, 16'h3E8, 16'sh12C, 16'sh0, 16'h3E8},
      '{16'h0, 16'h3E8, 16'sh64, 16'sh0, 16'h0}};
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    edges(1);
    chkv({16'h0, flowCommand}, 32'h0);
    chkb(engageAllowed, 1'b0);
    for (int i = 0; i < 12; i++) begin
      param(1'b1, rstIdx[i], 32'h0);
      chkv(rdata, rstVal[i]);
      chkb(pvld, 1'b1);
    end
    param(1'b1, 16'h0400, 32'h0);
    chkb(perr, 1'b1);
    param(1'b0, `CLSV_IDX_STATUS, 32'h0);
    chkb(perr, 1'b1);
    param(1'b0, `CLSV_IDX_GAIN, 32'hC9);
    chkb(perr, 1'b1);
    param(1'b0, `CLSV_IDX_LIMIT, 32'h3E9);
    chkb(perr, 1'b1);
    param(1'b0, `CLSV_IDX_SELECT, 32'h2);
    chkb(perr, 1'b1);
    param(1'b0, `CLSV_IDX_SPAN, 32'h0);
    chkb(perr, 1'b1);
    param(1'b0, `CLSV_IDX_HOLD, 32'h0);
    chkb(perr, 1'b1);
    foreach (rows[i]) begin
      param(1'b0, `CLSV_IDX_GAIN, {16'h0, rows[i].gain});
      param(1'b0, `CLSV_IDX_SCALE, {16'h0, rows[i].scale});
      flowChk(rows[i].sp, rows[i].pos, rows[i].flow, rows[i].flow);
    end
    edges(20);
    chkb(bridgeEnable, 1'b1);
    param(1'b0, `CLSV_IDX_GAIN, 32'h32);
    param(1'b0, `CLSV_IDX_OFFSET, 32'h3E9);
    chkb(perr, 1'b1);
    param(1'b0, `CLSV_IDX_OFFSET, 32'h14);
    flowChk(16'sh28, 16'sh0, 16'hC8, 16'hDC);
    param(1'b0, `CLSV_IDX_HOLD, 32'h1);
    flowChk(16'sh0A, 16'sh0, 16'h32, 16'h46);
    waitFor(0, 1'b1, 60);
    edges(1);
    chkv({16'h0, spoolCommand}, 32'h0);
    flowChk(16'sh0B, 16'sh0, 16'h37, 16'h0);
    chkb(spoolNeutral, 1'b0);
    edges(1);
    chkv({16'h0, spoolCommand}, 32'h4B);
    param(1'b0, `CLSV_IDX_HOLD, 32'hBB8);
    param(1'b0, `CLSV_IDX_OFF_DELAY, 32'h2);
    flowChk(16'sh0, 16'sh0, 16'h0, 16'h0);
    waitFor(1, 1'b0, 60);
    flowChk(16'sh14, 16'sh0, 16'h64, 16'h78);
    chkb(bridgeEnable, 1'b1);
    // Dead-band zero keeps small speed-scaled flows out of neutral.
    param(1'b0, `CLSV_IDX_DEADBAND, 32'h0);
    param(1'b0, `CLSV_IDX_SELECT, 32'h3);
    param(1'b0, `CLSV_IDX_SPAN, 32'hA0);
    for (int k = 0; k < 6; k++) begin
      param(1'b0, `CLSV_IDX_SENS0 + 16'(k), {16'h0, sens[k]});
    end
    speedMapped <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      vehicleSpeedValue <= spd[k];
      flowChk(16'sh14, 16'sh0, spdFlow[k], spdFlow[k] + 16'h14);
    end
    speedMapped <= 1'b0;
    flowChk(16'sh14, 16'sh0, 16'h64, 16'h78);
    param(1'b1, `CLSV_IDX_STATUS, 32'h0);
    chkv(rdata, 32'h00020064);
    wheelPositionDelta <= 16'sh6;
    edges(2);
    chkb(engageAllowed, 1'b1);
    wheelPositionDelta <= 16'sh5;
    edges(2);
    chkb(engageAllowed, 1'b0);
    param(1'b0, `CLSV_IDX_WINDOW, 32'h2);
    wheelPositionDelta <= 16'shFFF9;
    edges(2);
    wheelPositionDelta <= 16'sh0;
    edges(3);
    chkb(engageAllowed, 1'b1);
    waitFor(2, 1'b0, 40);
    tally_and_finish();
  end
endmodule : clsv_steer_ctrl_tb_top
